// file: rtl/fractional_pll_clock_gen.sv
// clock generation for the data converters, modelled as tick streams
// assumes the reference pin is already synchronous to mclk and that
// every reference period spans more mclk cycles than the multiplier
//
// Behaviour
// - oscillator divided by four, then master prescaler
// - reference prescaler selectable as one or two
// - fraction held as 24 bits in three words
// - master clock is 256 times sample rate
// - oscillator equals four times prescaler times master
// - pin carries the master prescaler input clock
// - pin clock optionally divided by 2, 3, 4
// - multiplication happens only with the pll chosen
// - prescaler fed from pin or pll output
// - master mode frame sync is master clock/256
// - selector value four routes pll clock out
`timescale 1ns/100ps
module fractional_pll_clock_gen (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ref_clock_pin,
   input wire logic config_load,
   input wire logic pll_enable,
   input wire logic ref_prescale_two,
   input wire logic [clock_gen_pkg::INT_W-1:0] pll_integer_multiplier,
   input wire logic [clock_gen_pkg::REG_W-1:0] pll_fraction_hi,
   input wire logic [clock_gen_pkg::REG_W-1:0] pll_fraction_mid,
   input wire logic [clock_gen_pkg::REG_W-1:0] pll_fraction_lo,
   input wire logic [clock_gen_pkg::PRE_W-1:0] master_prescale,
   input wire logic master_mode,
   input wire logic [2:0] pin_function_select,
   input wire logic [1:0] pin_clock_divide,
   output logic internal_master_clock,
   output logic frame_sync,
   output logic pll_oscillator_tick,
   output logic multi_function_pin_out,
   output logic multi_function_pin_oe,
   output logic [clock_gen_pkg::FRAC_W-1:0] pll_fraction_value
);
   import clock_gen_pkg::*;

   // ==========================================================
   // state
   typedef struct packed {
      logic ref_prev;
      logic ref_tick;
      logic pll_en;
      logic pre_two;
      logic [INT_W-1:0] int_mult;
      logic [FRAC_W-1:0] frac;
      logic [PRE_W-1:0] master_pre;
      logic master;
      pin_function_t pin_sel;
      logic [1:0] pin_div;
      logic [FRAC_W-1:0] frac_acc;
      logic carry;
      logic [BURST_W-1:0] burst;
      logic osc_tick;
      logic internal_master_clock_out;
      logic fs_out;
      logic pin_out;
      logic pin_oe;
      logic [8:0] cnt_internal_master_clock;
      logic [2:0] cnt_osc;
      logic [2:0] cnt_src;
      logic [1:0] cnt_ref;
      logic src_seen;
   } gen_state_t;

   gen_state_t st_reg;
   gen_state_t st_next;
   logic ref_div_tick;
   logic post_tick;
   logic src_tick;
   logic internal_master_clock_tick;
   logic fs_tick;
   logic pin_tick;
   logic [FRAC_W:0] frac_sum;
   logic [1:0] ref_divisor;
   logic [2:0] pin_divisor;

   // ==========================================================
   // divider chain
   assign ref_divisor = st_reg.pre_two ? REF_DIV_TWO : REF_DIV_ONE;
   // the master prescaler sees the pll path or the raw pin
   assign src_tick = st_reg.pll_en ? post_tick : st_reg.ref_tick;
   assign pin_divisor = {1'b0, st_reg.pin_div} + 3'h1;

   tick_divider #(.WIDTH(2)) u_ref_pre (
      .mclk(mclk),
      .rst(rst),
      .tick_in(st_reg.ref_tick),
      .divisor(ref_divisor),
      .tick_out(ref_div_tick)
   );

   tick_divider #(.WIDTH(3)) u_post (
      .mclk(mclk),
      .rst(rst),
      .tick_in(st_reg.osc_tick),
      .divisor(POST_DIV),
      .tick_out(post_tick)
   );

   tick_divider #(.WIDTH(PRE_W)) u_master (
      .mclk(mclk),
      .rst(rst),
      .tick_in(src_tick),
      .divisor(st_reg.master_pre),
      .tick_out(internal_master_clock_tick)
   );

   tick_divider #(.WIDTH(9)) u_frame (
      .mclk(mclk),
      .rst(rst),
      .tick_in(internal_master_clock_tick),
      .divisor(FRAME_DIV),
      .tick_out(fs_tick)
   );

   tick_divider #(.WIDTH(3)) u_pin (
      .mclk(mclk),
      .rst(rst),
      .tick_in(src_tick),
      .divisor(pin_divisor),
      .tick_out(pin_tick)
   );

   // fraction sum, the top bit is the overflow carry
   assign frac_sum = {1'b0, st_reg.frac_acc} + {1'b0, st_reg.frac};

   // ==========================================================
   // next state
   always_comb begin
      st_next = st_reg;
      st_next.ref_prev = ref_clock_pin;
      st_next.ref_tick = ref_clock_pin & ~st_reg.ref_prev;
      // configuration only moves on a load so all fields change together
      if (config_load) begin
         st_next.pll_en = pll_enable;
         st_next.pre_two = ref_prescale_two;
         st_next.int_mult = pll_integer_multiplier;
         st_next.frac = {pll_fraction_hi[FRAC_HI_W-1:0],
                         pll_fraction_mid, pll_fraction_lo};
         st_next.master_pre = master_prescale;
         st_next.master = master_mode;
         st_next.pin_sel = pin_function_t'(pin_function_select);
         st_next.pin_div = pin_clock_divide;
      end
      // fractional-n: n or n+1 oscillator ticks per prescaled reference tick
      st_next.carry = 1'b0;
      if (!st_reg.pll_en) begin
         st_next.burst = '0;
         st_next.frac_acc = '0;
      end else begin
         st_next.burst = st_reg.burst - BURST_W'(st_reg.burst != '0);
         if (ref_div_tick) begin
            st_next.frac_acc = frac_sum[FRAC_W-1:0];
            st_next.carry = frac_sum[FRAC_W];
            st_next.burst = st_next.burst
                          + BURST_W'(st_reg.int_mult)
                          + BURST_W'(frac_sum[FRAC_W]);
         end
      end
      // ticks are issued back to back; only the average rate matters
      st_next.osc_tick = st_reg.pll_en && (st_reg.burst != '0);
      st_next.internal_master_clock_out = internal_master_clock_tick;
      st_next.fs_out = fs_tick & st_reg.master;
      unique case (st_reg.pin_sel)
         PIN_PLL_CLOCK: st_next.pin_out = pin_tick;
         PIN_HIGH: st_next.pin_out = 1'b1;
         PIN_CHIP_SELECT, PIN_JACK, PIN_TEMP, PIN_MUTE, PIN_LOCK,
         PIN_LOW: st_next.pin_out = 1'b0;
      endcase
      st_next.pin_oe = st_reg.pin_sel != PIN_CHIP_SELECT;
      // helper counts for the checks below
      st_next.cnt_internal_master_clock = fs_tick ? 9'(internal_master_clock_tick)
                        : st_reg.cnt_internal_master_clock + 9'(internal_master_clock_tick);
      st_next.cnt_osc = post_tick ? 3'(st_reg.osc_tick)
                      : st_reg.cnt_osc + 3'(st_reg.osc_tick);
      st_next.cnt_src = pin_tick ? 3'(src_tick)
                      : st_reg.cnt_src + 3'(src_tick);
      st_next.cnt_ref = ref_div_tick ? 2'(st_reg.ref_tick)
                      : st_reg.cnt_ref + 2'(st_reg.ref_tick);
      if (pin_tick) begin
         st_next.src_seen = 1'b1;
      end
      if (config_load) begin
         st_next.src_seen = 1'b0;
      end
   end

   // ==========================================================
   // state register with documented defaults
   always_ff @(posedge mclk) begin
      if (rst) begin
         st_reg <= '0;
         st_reg.ref_prev <= 1'b1; // no false edge if pin is high
         st_reg.int_mult <= RST_INT_MULT;
         st_reg.frac <= {RST_FRAC_HI[FRAC_HI_W-1:0], RST_FRAC_MID,
                         RST_FRAC_LO};
         st_reg.master_pre <= RST_MASTER_PRE;
         st_reg.pin_sel <= PIN_CHIP_SELECT;
      end else begin
         st_reg <= st_next;
      end
   end

   assign internal_master_clock = st_reg.internal_master_clock_out;
   assign frame_sync = st_reg.fs_out;
   assign pll_oscillator_tick = st_reg.osc_tick;
   assign multi_function_pin_out = st_reg.pin_out;
   assign multi_function_pin_oe = st_reg.pin_oe;
   assign pll_fraction_value = st_reg.frac;

   // ==========================================================
   // checks
   property p_post_four;
      @(posedge mclk) disable iff (rst)
      post_tick |-> st_reg.cnt_osc == POST_DIV;
   endproperty
   a_post_four: assert property (p_post_four)
      else $error("post scaler did not divide by four");

   property p_ref_prescale;
      @(posedge mclk) disable iff (rst)
      (ref_div_tick && $past(st_reg.pre_two))
      |-> st_reg.cnt_ref == REF_DIV_TWO;
   endproperty
   a_ref_prescale: assert property (p_ref_prescale)
      else $error("reference prescaler did not divide by two");

   property p_fraction_hold;
      @(posedge mclk) disable iff (rst)
      !config_load |=> $stable(pll_fraction_value);
   endproperty
   a_fraction_hold: assert property (p_fraction_hold)
      else $error("fraction changed without a load");

   property p_frame_count;
      @(posedge mclk) disable iff (rst)
      fs_tick |-> st_reg.cnt_internal_master_clock == FRAME_DIV;
   endproperty
   a_frame_count: assert property (p_frame_count)
      else $error("frame sync not one per 256 master clocks");

   property p_no_pll_no_osc;
      @(posedge mclk) disable iff (rst)
      !st_reg.pll_en |=> ##1 !pll_oscillator_tick;
   endproperty
   a_no_pll_no_osc: assert property (p_no_pll_no_osc)
      else $error("oscillator ticked with pll not chosen");

   property p_carry_adds;
      @(posedge mclk) disable iff (rst)
      (st_reg.pll_en && ref_div_tick && st_reg.burst == '0
       && frac_sum[FRAC_W] && !config_load)
      |=> st_reg.burst == BURST_W'(st_reg.int_mult) + BURST_W'(1);
   endproperty
   a_carry_adds: assert property (p_carry_adds)
      else $error("fraction overflow did not add one count");

   property p_pin_divide;
      @(posedge mclk) disable iff (rst)
      (pin_tick && st_reg.src_seen) |-> st_reg.cnt_src == pin_divisor;
   endproperty
   a_pin_divide: assert property (p_pin_divide)
      else $error("pin clock divider ratio wrong");

   property p_pin_route;
      @(posedge mclk) disable iff (rst)
      (st_reg.pin_sel == PIN_PLL_CLOCK && pin_tick && !config_load)
      |=> multi_function_pin_out && multi_function_pin_oe;
   endproperty
   a_pin_route: assert property (p_pin_route)
      else $error("pll clock not routed to the pin");

   property p_master_source;
      @(posedge mclk) disable iff (rst)
      internal_master_clock_tick |-> $past(src_tick);
   endproperty
   a_master_source: assert property (p_master_source)
      else $error("master clock tick without a source tick");

   c_frame: cover property (@(posedge mclk) disable iff (rst)
      frame_sync);
   c_pin_clock: cover property (@(posedge mclk) disable iff (rst)
      st_reg.pin_sel == PIN_PLL_CLOCK && multi_function_pin_out);
   c_carry: cover property (@(posedge mclk) disable iff (rst)
      st_reg.pll_en && st_reg.carry);
endmodule

// file: pkg/clock_gen_pkg.sv
// constants and types shared by the clock generation block
// assumes one 200 MHz clock and a synchronous active-high reset
package clock_gen_pkg;
   // ==========================================================
   // field widths
   localparam int REG_W = 9;
   localparam int FRAC_W = 24;
   localparam int INT_W = 4;
   localparam int PRE_W = 3;
   localparam int BURST_W = 6;
   // ==========================================================
   // fixed division factors
   localparam logic [2:0] POST_DIV = 3'h4;
   localparam logic [8:0] FRAME_DIV = 9'h100;
   localparam logic [1:0] REF_DIV_ONE = 2'h1;
   localparam logic [1:0] REF_DIV_TWO = 2'h2;
   // ==========================================================
   // fraction field positions inside the three 9-bit words
   localparam int FRAC_HI_LSB = 18;
   localparam int FRAC_HI_W = 6;
   localparam int FRAC_MID_LSB = 9;
   // ==========================================================
   // values after reset
   localparam logic [INT_W-1:0] RST_INT_MULT = 4'h8;
   localparam logic [REG_W-1:0] RST_FRAC_HI = 9'h00C;
   localparam logic [REG_W-1:0] RST_FRAC_MID = 9'h093;
   localparam logic [REG_W-1:0] RST_FRAC_LO = 9'h0E9;
   localparam logic [PRE_W-1:0] RST_MASTER_PRE = 3'h1;
   // ==========================================================
   // multi-function pin selector codes
   typedef enum logic [2:0] {
      PIN_CHIP_SELECT = 3'b000,
      PIN_JACK = 3'b001,
      PIN_TEMP = 3'b010,
      PIN_MUTE = 3'b011,
      PIN_PLL_CLOCK = 3'b100,
      PIN_LOCK = 3'b101,
      PIN_HIGH = 3'b110,
      PIN_LOW = 3'b111
   } pin_function_t;
endpackage

// file: rtl/tick_divider.sv
// integer divider for a stream of one-cycle ticks
// assumes tick_in is synchronous to mclk; divisor 0 acts as 1
`timescale 1ns/100ps
module tick_divider #(
   parameter int WIDTH = 3
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic tick_in,
   input wire logic [WIDTH-1:0] divisor,
   output logic tick_out
);
   // ==========================================================
   // state
   typedef struct packed {
      logic [WIDTH-1:0] cnt;
      logic out;
   } div_state_t;

   div_state_t st_reg;
   div_state_t st_next;
   logic [WIDTH-1:0] limit;

   // last count before wrap; zero divisor behaves as divide by one
   assign limit = (divisor == '0) ? '0 : divisor - WIDTH'(1);

   // count input ticks, pulse once per divisor ticks
   always_comb begin
      st_next = st_reg;
      st_next.out = 1'b0;
      if (tick_in) begin
         if (st_reg.cnt >= limit) begin
            st_next.cnt = '0;
            st_next.out = 1'b1;
         end else begin
            st_next.cnt = st_reg.cnt + WIDTH'(1);
         end
      end
   end

   // state register
   always_ff @(posedge mclk) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign tick_out = st_reg.out;
endmodule

// file: test/ref_clock_source.sv
// free-running reference clock model for the reference pin
// assumes the bench clock is mclk; period counted in mclk cycles
`timescale 1ns/100ps
module ref_clock_source #(
   parameter int PERIOD = 24
) (
   input wire logic mclk,
   output logic ref_level
);
   int count = 0;
   // a crystal runs free; edges move off the sampling edge of mclk
   always @(negedge mclk) begin
      count = (count + 1) % PERIOD;
      ref_level = (count < PERIOD / 2);
   end
endmodule

// file: test/testbench.sv
// self-checking bench for the clock generation block
// assumes ref_clock_source drives the reference pin
`timescale 1ns/100ps
module testbench;
   import clock_gen_pkg::*;
   // ==========================================================
   // signals
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic ref_level, ld = 1'b0, pll_on = 1'b0, two = 1'b0, mmode = 1'b0;
   logic [INT_W-1:0] mult = 4'h8;
   logic [REG_W-1:0] f_hi = 9'h000, f_mid = 9'h000, f_lo = 9'h000;
   logic [PRE_W-1:0] pre = 3'h1;
   logic [2:0] sel = 3'h0;
   logic [1:0] pdiv = 2'h0;
   logic imc, fsync, osc, pin_out, pin_oe, ref_prev = 1'b0;
   logic [FRAC_W-1:0] frac_val;
   logic [31:0] lfsr = 32'hDEDB4239;
   int failures = 0, total_checks = 0, exp_q[$];
   int watch = 0, primed = 0, frac_wait = 0, win_len = 8, ref_n = 0;
   int osc_n = 0, mc_n = 0, fs_n = 0, pin_n = 0;
   initial forever #2.5 mclk = ~mclk;
   ref_clock_source #(.PERIOD(24)) src (.mclk(mclk), .ref_level(ref_level));
   fractional_pll_clock_gen dut (
      .mclk(mclk),
      .rst(rst),
      .ref_clock_pin(ref_level),
      .config_load(ld),
      .pll_enable(pll_on),
      .ref_prescale_two(two),
      .pll_integer_multiplier(mult),
      .pll_fraction_hi(f_hi),
      .pll_fraction_mid(f_mid),
      .pll_fraction_lo(f_lo),
      .master_prescale(pre),
      .master_mode(mmode),
      .pin_function_select(sel),
      .pin_clock_divide(pdiv),
      .internal_master_clock(imc),
      .frame_sync(fsync),
      .pll_oscillator_tick(osc),
      .multi_function_pin_out(pin_out),
      .multi_function_pin_oe(pin_oe),
      .pll_fraction_value(frac_val)
   );
   // ==========================================================
   // helpers
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check_frac(input logic [23:0] e, input logic [23:0] g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("BAD fraction expected %h seen %h", e, g);
      end
   endtask
   task automatic check_cnt(input string n, input int e, input int g);
      total_checks++;
      if (g != e) begin
         failures++;
         $display("BAD %s expected %0d seen %0d", n, e, g);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // fraction is checked two edges after the loading edge
   task automatic load(input int n, input logic [23:0] f, input int p,
                       input logic d, input logic on);
      @(negedge mclk);
      mult = 4'(n);
      {f_hi[5:0], f_mid, f_lo} = f;
      f_hi[8:6] = lfsr[8:6];
      pre = 3'(p);
      two = d;
      pll_on = on;
      ld = 1'b1;
      @(negedge mclk);
      ld = 1'b0;
      exp_q = {int'(f), int'(sel != 3'h0)};
      frac_wait = 2;
      repeat (3) @(negedge mclk);
   endtask
   // counts pulses over w reference rises, after old bursts drain
   task automatic measure(input int w, input int oe, input int me,
                          input int fe, input int pe);
      int t;
      t = 0;
      repeat (80) @(negedge mclk);
      win_len = w;
      exp_q = {oe, me, fe, pe};
      primed = 0;
      watch = 1;
      while (watch != 0 && t < 9000) begin
         @(negedge mclk);
         t++;
      end
      if (watch != 0) begin
         failures++;
         $display("BAD window expected end seen none");
         watch = 0;
      end
   endtask
   // ==========================================================
   // monitor: windows run from one reference rise to a later one
   always @(posedge mclk) begin
      if (frac_wait > 0) begin
         frac_wait--;
         if (frac_wait == 0) begin
            check_frac(24'(exp_q.pop_front()), frac_val);
            check_cnt("oe", exp_q.pop_front(), int'(pin_oe === 1'b1));
         end
      end
      if (primed == 1) begin
         osc_n += (osc === 1'b1);
         mc_n += (imc === 1'b1);
         fs_n += (fsync === 1'b1);
         pin_n += (pin_out === 1'b1);
      end
      if (ref_level && !ref_prev && watch == 1) begin
         if (primed == 1) ref_n++;
         if (primed == 0) begin
            {primed, ref_n, osc_n, mc_n, fs_n, pin_n} = '0;
            primed = 1;
         end else if (ref_n == win_len) begin
            check_cnt("osc", exp_q.pop_front(), osc_n);
            check_cnt("master", exp_q.pop_front(), mc_n);
            check_cnt("frame", exp_q.pop_front(), fs_n);
            check_cnt("pin", exp_q.pop_front(), pin_n);
            watch = 0;
            primed = 0;
         end
      end
      ref_prev = ref_level;
   end
   // ==========================================================
   // main sequence, inputs change on the falling edge
   initial begin
      repeat (2) @(negedge mclk);
      rst = 1'b0;
      exp_q = {32'h003126E9, 0};
      frac_wait = 2;
      repeat (4) @(negedge mclk);
      for (int i = 0; i < 6; i++) begin
         lfsr = next_rand(lfsr);
         load(6 + lfsr[31:28] % 7, lfsr[23:0], 1, 1'b0, 1'b1);
      end
      // pll on, ratio 8: prescaler and pin divider swept together
      sel = 3'h4;
      for (int i = 0; i < 4; i++) begin
         pdiv = 2'(3 - i);
         load(8, 24'h000000, i + 1, 1'b0, 1'b1);
         measure(24, 192, 48 / (i + 1), 0, 48 / (4 - i));
      end
      // ratio 8.5 behind the divide-by-two reference prescaler
      sel = 3'h7;
      load(8, 24'h800000, 2, 1'b1, 1'b1);
      measure(32, 136, 17, 0, 0);
      // range ends of the integer multiplier; pin held high every cycle
      sel = 3'h6;
      load(6, 24'h000000, 3, 1'b0, 1'b1);
      measure(8, 48, 4, 0, 192);
      load(12, 24'h000000, 3, 1'b0, 1'b1);
      measure(8, 96, 8, 0, 192);
      // master mode over exactly 256 master clocks
      mmode = 1'b1;
      sel = 3'h0;
      load(8, 24'h000000, 1, 1'b0, 1'b1);
      measure(128, 1024, 256, 1, 0);
      // pll bypassed: prescaler and pin count raw reference edges
      // frame phase is unknown here, so master mode is left off
      mmode = 1'b0;
      sel = 3'h4;
      pdiv = 2'h2;
      load(8, 24'h000000, 4, 1'b0, 1'b0);
      measure(24, 0, 6, 0, 8);
      stop_test();
   end
   // watchdog sized well past the expected run
   initial begin
      #(60000 * 5);
      failures++;
      $display("BAD watchdog expected finish seen hang");
      stop_test();
   end
endmodule
